// File: bsf_alu.v
// Combinational shift, rotate, swap, bit-transfer and flag unit.
// Assumes the caller writes result and flags back in the cycle it executes.
`timescale 1ns/100ps
`include "bsf_map.vh"

module bsf_alu
(
  input  wire [4:0] op,
  input  wire [7:0] operand,
  input  wire [2:0] bit_sel,
  input  wire [7:0] flags_in,
  output reg  [7:0] result,
  output reg  [7:0] flags_out,
  output reg        write_reg,
  output reg        known
);

  reg shift_op;

  always @*
  begin
    result    = operand;
    flags_out = flags_in;
    write_reg = 1'b0;
    known     = 1'b1;
    shift_op  = 1'b1;
    case (op)
      `BSF_OP_SHIFT_LEFT:
      begin
        result = {operand[6:0], 1'b0};
        flags_out[`BSF_FLAG_C] = operand[7];
      end
      `BSF_OP_SHIFT_RIGHT:
      begin
        result = {1'b0, operand[7:1]};
        flags_out[`BSF_FLAG_C] = operand[0];
      end
      `BSF_OP_ROT_LEFT:
      begin
        result = {operand[6:0], flags_in[`BSF_FLAG_C]};
        flags_out[`BSF_FLAG_C] = operand[7];
      end
      `BSF_OP_ROT_RIGHT:
      begin
        result = {flags_in[`BSF_FLAG_C], operand[7:1]};
        flags_out[`BSF_FLAG_C] = operand[0];
      end
      `BSF_OP_ARITH_RIGHT:
      begin
        result = {operand[7], operand[7:1]};
        flags_out[`BSF_FLAG_C] = operand[0];
      end
      default:
        shift_op = 1'b0;
    endcase
    if (shift_op)
    begin
      write_reg = 1'b1;
      flags_out[`BSF_FLAG_Z] = (result == 8'h00);
      flags_out[`BSF_FLAG_N] = result[7];
      flags_out[`BSF_FLAG_V] = result[7] ^ flags_out[`BSF_FLAG_C];
    end
    else
    begin
      case (op)
        `BSF_OP_SWAP:
        begin
          result    = {operand[3:0], operand[7:4]};
          write_reg = 1'b1;
        end
        `BSF_OP_STAT_SET:  flags_out[bit_sel] = 1'b1;
        `BSF_OP_STAT_CLR:  flags_out[bit_sel] = 1'b0;
        `BSF_OP_BIT_STORE: flags_out[`BSF_FLAG_T] = operand[bit_sel];
        `BSF_OP_BIT_LOAD:
        begin
          result[bit_sel] = flags_in[`BSF_FLAG_T];
          write_reg = 1'b1;
        end
        `BSF_OP_CARRY_SET: flags_out[`BSF_FLAG_C] = 1'b1;
        `BSF_OP_CARRY_CLR: flags_out[`BSF_FLAG_C] = 1'b0;
        `BSF_OP_NEG_SET:   flags_out[`BSF_FLAG_N] = 1'b1;
        `BSF_OP_NEG_CLR:   flags_out[`BSF_FLAG_N] = 1'b0;
        `BSF_OP_ZERO_SET:  flags_out[`BSF_FLAG_Z] = 1'b1;
        `BSF_OP_ZERO_CLR:  flags_out[`BSF_FLAG_Z] = 1'b0;
        `BSF_OP_IRQ_EN:    flags_out[`BSF_FLAG_I] = 1'b1;
        `BSF_OP_IRQ_DIS:   flags_out[`BSF_FLAG_I] = 1'b0;
        `BSF_OP_SIGN_SET:  flags_out[`BSF_FLAG_S] = 1'b1;
        `BSF_OP_SIGN_CLR:  flags_out[`BSF_FLAG_S] = 1'b0;
        `BSF_OP_OVF_SET:   flags_out[`BSF_FLAG_V] = 1'b1;
        `BSF_OP_OVF_CLR:   flags_out[`BSF_FLAG_V] = 1'b0;
        `BSF_OP_SET: flags_out[`BSF_FLAG_T] = 1'b1;
        default:     known = 1'b0;
      endcase
    end
  end

endmodule

// File: bsf_map.vh
// Offsets, field positions, opcodes and reset values of the bit/shift/flag datapath.
// Included by every design file of the block; definitions only.
`ifndef BSF_MAP_VH
`define BSF_MAP_VH

// Register byte addresses on the AXI4-Lite slave
`define BSF_A_CMD      8'h00
`define BSF_A_STATUS   8'h04
`define BSF_A_REG_SEL  8'h08
`define BSF_A_REG_DATA 8'h0c
`define BSF_A_IO_SEL   8'h10
`define BSF_A_IO_DATA  8'h14
`define BSF_A_STACK    8'h18

// Command word fields
`define BSF_F_OP_HI  4
`define BSF_F_OP_LO  0
`define BSF_F_REG_HI 12
`define BSF_F_REG_LO 8
`define BSF_F_BIT_HI 18
`define BSF_F_BIT_LO 16
`define BSF_F_IO_HI  29
`define BSF_F_IO_LO  24

// Stack register fields
`define BSF_F_STK_EMPTY 5
`define BSF_F_STK_FULL  6
`define BSF_F_STK_ERR   8
`define BSF_F_BAD_OP    9

// Status register bit positions
`define BSF_FLAG_C 0
`define BSF_FLAG_Z 1
`define BSF_FLAG_N 2
`define BSF_FLAG_V 3
`define BSF_FLAG_S 4
`define BSF_FLAG_H 5
`define BSF_FLAG_T 6
`define BSF_FLAG_I 7

// Opcodes
`define BSF_OP_PUSH     5'h00
`define BSF_OP_POP      5'h01
`define BSF_OP_IO_SET   5'h02
`define BSF_OP_IO_CLR   5'h03
`define BSF_OP_SHIFT_LEFT  5'h04
`define BSF_OP_SHIFT_RIGHT 5'h05
`define BSF_OP_ROT_LEFT    5'h06
`define BSF_OP_ROT_RIGHT   5'h07
`define BSF_OP_ARITH_RIGHT 5'h08
`define BSF_OP_SWAP        5'h09
`define BSF_OP_STAT_SET    5'h0a
`define BSF_OP_STAT_CLR    5'h0b
`define BSF_OP_BIT_STORE   5'h0c
`define BSF_OP_BIT_LOAD    5'h0d
`define BSF_OP_CARRY_SET   5'h0e
`define BSF_OP_CARRY_CLR   5'h0f
`define BSF_OP_NEG_SET     5'h10
`define BSF_OP_NEG_CLR     5'h11
`define BSF_OP_ZERO_SET    5'h12
`define BSF_OP_ZERO_CLR    5'h13
`define BSF_OP_IRQ_EN      5'h14
`define BSF_OP_IRQ_DIS     5'h15
`define BSF_OP_SIGN_SET    5'h16
`define BSF_OP_SIGN_CLR    5'h17
`define BSF_OP_OVF_SET     5'h18
`define BSF_OP_OVF_CLR     5'h19
`define BSF_OP_SET      5'h1a

// Sizes and reset values
`define BSF_GPR_COUNT   32
`define BSF_IO_COUNT    64
`define BSF_STACK_DEPTH 16
`define BSF_STATUS_RST  8'h00
`define BSF_DATA_RST    8'h00
`define BSF_RESP_OKAY   2'b00
`define BSF_RESP_SLVERR 2'b10

`endif

// File: bsf_monitor.sv
// Checker for bsf_top: AXI4-Lite handshakes and the flag effects of commands.
// Assumes ce stays high and one write at a time, as the slave allows.
`timescale 1ns/100ps
module bsf_monitor
(
  input wire        aclk,
  input wire        aresetn,
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [7:0]  cpu_status_register,
  input wire        global_irq_en
);
  reg        aw_got;
  reg        w_got;
  reg [7:0]  adr;
  reg [31:0] cmd;
  reg [3:0]  stb;
  wire [4:0] op = cmd[4:0];
  wire       ex = adr == 8'h00 && stb == 4'hf;
  wire [7:0] st = cpu_status_register;

  // Remember the write being assembled until its response shows
  always @(posedge aclk)
  begin
    if (!aresetn || s_axi_bvalid)
    begin
      aw_got <= 1'b0;
      w_got  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got <= 1'b1;
        adr    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got <= 1'b1;
        cmd   <= s_axi_wdata;
        stb   <= s_axi_wstrb;
      end
    end
  end

  function automatic [7:0] fm(input [4:0] o);
    case (o)
      5'h0e, 5'h0f: fm = 8'h01;
      5'h10, 5'h11: fm = 8'h04;
      5'h12, 5'h13: fm = 8'h02;
      5'h14, 5'h15: fm = 8'h80;
      5'h16, 5'h17: fm = 8'h10;
      5'h18, 5'h19: fm = 8'h08;
      default:      fm = 8'h40;
    endcase
  endfunction

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_flag(lo, hi);
    $rose(s_axi_bvalid) && ex && op >= lo && op <= hi |->
      st == (op[0] ? $past(st) & ~fm(op) : $past(st) | fm(op));
  endproperty

  a_cnz_ops: assert property (p_flag(5'h0e, 5'h13)) else $error("carry/neg/zero op wrong");
  a_irq_ops: assert property (p_flag(5'h14, 5'h15)) else $error("irq flag op wrong");
  a_signed_ops: assert property (p_flag(5'h16, 5'h17)) else $error("signed flag op wrong");
  a_ovf_set: assert property (p_flag(5'h18, 5'h18)) else $error("overflow set wrong");
  a_ovf_clr_tset: assert property (p_flag(5'h19, 5'h1a)) else $error("overflow clear or T set wrong");
  a_status_bit: assert property ($rose(s_axi_bvalid) && ex && (op == 5'h0a || op == 5'h0b) |->
    st == (op[0] ? $past(st) & ~(8'h01 << cmd[18:16]) : $past(st) | (8'h01 << cmd[18:16])))
    else $error("status bit set/clear wrong");
  a_shift_flags: assert property ($rose(s_axi_bvalid) && ex && op >= 5'h04 && op <= 5'h08 |->
    st[7:4] == $past(st[7:4]) && st[3] == (st[2] ^ st[0])) else $error("shift flags wrong");
  a_flags_kept: assert property ($rose(s_axi_bvalid) && ex && (op <= 5'h03 || op == 5'h09 || op == 5'h0d)
    |-> $stable(st)) else $error("flags changed");
  a_bst_only_t: assert property ($rose(s_axi_bvalid) && ex && op == 5'h0c |->
    ((st ^ $past(st)) & 8'hbf) == 8'h00) else $error("bit store touched other flags");
  a_irq_mirror: assert property (global_irq_en == st[7]) else $error("irq enable not mirrored");
  a_write_answer: assert property (aw_got && w_got && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write response late");
  a_unmapped_err: assert property ($rose(s_axi_bvalid) && adr > 8'h18 |-> s_axi_bresp == 2'b10)
    else $error("unmapped write not refused");
  a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("accepted while response pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##1 !s_axi_rvalid)
    else $error("read answer wrong");

  c_rotate: cover property ($rose(s_axi_bvalid) && ex && op == 5'h06);
  c_store: cover property ($rose(s_axi_bvalid) && ex && op == 5'h0c);
  c_slverr: cover property ($rose(s_axi_bvalid) && s_axi_bresp == 2'b10);
endmodule

bind bsf_top bsf_monitor bsf_monitor_inst (.*);

// File: bsf_stack.v
// Byte stack with push and pop strobes, depth and full/empty indication.
// Assumes the caller never pushes when full nor pops when empty.
`timescale 1ns/100ps
`include "bsf_map.vh"

module bsf_stack
(
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       ce,
  input  wire       push,
  input  wire       pop,
  input  wire [7:0] push_data,
  output wire [7:0] top_data,
  output reg  [4:0] depth,
  output wire       full,
  output wire       empty
);

  reg  [7:0] mem [0:`BSF_STACK_DEPTH-1];
  wire [3:0] top_index;

  assign top_index = depth[3:0] - 4'h1;
  assign top_data  = mem[top_index];
  assign full      = (depth == 5'h10);
  assign empty     = (depth == 5'h00);

  always @(posedge aclk)
  begin
    if (!aresetn)
      depth <= 5'h00;
    else if (ce)
    begin
      if (push && !full)
      begin
        mem[depth[3:0]] <= push_data;
        depth           <= depth + 5'h01;
      end
      else if (pop && !empty)
        depth <= depth - 5'h01;
    end
  end

endmodule

// File: bsf_top.v
// Bit, shift, rotate and flag execution datapath with register file, I/O space and stack.
// Assumes an AXI4-Lite master on aclk; commands are executed by writing the command register.
//
// How it works
// - Left shift moves bits up, zero into bit 0, updates Z C N V.
// - Right shift moves bits down, zero into bit 7, updates Z C N V.
// - Rotate left: old carry into bit 0, old bit 7 into carry.
// - Rotate right: old carry into bit 7, old bit 0 into carry.
// - Arithmetic right shift keeps bit 7, shifts bits 0..6, updates Z C N V.
// - Nibble swap exchanges the register halves, flags untouched.
// - Status set/clear writes one chosen status bit only.
// - Bit store copies chosen register bit into T, nothing else changes.
// - Bit load copies T into chosen register bit, flags untouched.
// - Carry, negative and zero each have own set and clear operations.
// - Global interrupt enable has own set and clear operations.
// - Signed flag has own set and clear operations.
// - Overflow set operation touches only the overflow flag.
// - I/O bit set/clear forces one I/O register bit, flags untouched.
// - Push stores register on stack, pop loads it back, flags untouched.
// - Overflow clear and T set operations touch only their own flag.
`timescale 1ns/100ps
`include "bsf_map.vh"

module bsf_top
(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [7:0]  cpu_status_register,
  output wire        global_irq_en
);

  reg  [7:0]  gpr [0:`BSF_GPR_COUNT-1];
  reg  [7:0]  io_mem [0:`BSF_IO_COUNT-1];
  reg         aw_held;
  reg  [7:0]  aw_addr;
  reg         w_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg  [31:0] cmd_word;
  reg  [4:0]  reg_sel;
  reg  [5:0]  io_sel;
  reg         stack_err;
  reg         bad_op;
  reg  [31:0] next_rdata;
  reg  [1:0]  next_rresp;
  reg         wr_ok;
  integer     i;
  integer     j;

  wire        do_write;
  wire        do_cmd;
  wire [4:0]  cmd_op;
  wire [4:0]  cmd_reg;
  wire [2:0]  cmd_bit;
  wire [5:0]  cmd_io;
  wire [7:0]  operand;
  wire [7:0]  alu_result;
  wire [7:0]  alu_flags;
  wire        alu_write;
  wire        alu_known;
  wire        is_push;
  wire        is_pop;
  wire        is_io_set;
  wire        is_io_clr;
  wire        stk_push;
  wire        stk_pop;
  wire [7:0]  stk_top;
  wire [4:0]  stk_depth;
  wire        stk_full;
  wire        stk_empty;
  wire        stk_fault;
  wire [7:0]  io_word;

  // One write and one read outstanding; address and data taken in either order
  assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = ce && !w_held && !s_axi_bvalid;
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign do_write      = ce && aw_held && w_held && !s_axi_bvalid;
  assign do_cmd        = do_write && (aw_addr == `BSF_A_CMD) && (w_strb == 4'hf);

  assign cmd_op  = w_data[`BSF_F_OP_HI:`BSF_F_OP_LO];
  assign cmd_reg = w_data[`BSF_F_REG_HI:`BSF_F_REG_LO];
  assign cmd_bit = w_data[`BSF_F_BIT_HI:`BSF_F_BIT_LO];
  assign cmd_io  = w_data[`BSF_F_IO_HI:`BSF_F_IO_LO];
  assign operand = gpr[cmd_reg];
  assign io_word = io_mem[cmd_io];

  assign is_push   = (cmd_op == `BSF_OP_PUSH);
  assign is_pop    = (cmd_op == `BSF_OP_POP);
  assign is_io_set = (cmd_op == `BSF_OP_IO_SET);
  assign is_io_clr = (cmd_op == `BSF_OP_IO_CLR);
  assign stk_push  = do_cmd && is_push && !stk_full;
  assign stk_pop   = do_cmd && is_pop && !stk_empty;
  assign stk_fault = do_cmd && ((is_push && stk_full) || (is_pop && stk_empty));

  assign global_irq_en = cpu_status_register[`BSF_FLAG_I];

  bsf_alu u_alu
  (
    .op        (cmd_op),
    .operand   (operand),
    .bit_sel   (cmd_bit),
    .flags_in  (cpu_status_register),
    .result    (alu_result),
    .flags_out (alu_flags),
    .write_reg (alu_write),
    .known     (alu_known)
  );

  bsf_stack u_stack
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .push      (stk_push),
    .pop       (stk_pop),
    .push_data (operand),
    .top_data  (stk_top),
    .depth     (stk_depth),
    .full      (stk_full),
    .empty     (stk_empty)
  );

  // Write channel capture and response
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held      <= 1'b0;
      aw_addr      <= 8'h00;
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `BSF_RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `BSF_RESP_OKAY : `BSF_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Decode of the write address
  always @*
  begin
    case (aw_addr)
      `BSF_A_CMD, `BSF_A_STATUS, `BSF_A_REG_SEL, `BSF_A_REG_DATA,
      `BSF_A_IO_SEL, `BSF_A_IO_DATA, `BSF_A_STACK:
        wr_ok = 1'b1;
      default:
        wr_ok = 1'b0;
    endcase
  end

  // Software registers and command execution
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cpu_status_register <= `BSF_STATUS_RST;
      cmd_word            <= 32'h0000_0000;
      reg_sel             <= 5'h00;
      io_sel              <= 6'h00;
      stack_err           <= 1'b0;
      bad_op              <= 1'b0;
    end
    else if (ce && do_write)
    begin
      if (do_cmd)
      begin
        cmd_word <= w_data;
        if (alu_known)
          cpu_status_register <= alu_flags;
        if (stk_fault)
          stack_err <= 1'b1;
        if (!alu_known && !is_push && !is_pop && !is_io_set && !is_io_clr)
          bad_op <= 1'b1;
      end
      else
      begin
        case (aw_addr)
          `BSF_A_STATUS:
            if (w_strb[0])
              cpu_status_register <= w_data[7:0];
          `BSF_A_REG_SEL:
            if (w_strb[0])
              reg_sel <= w_data[4:0];
          `BSF_A_IO_SEL:
            if (w_strb[0])
              io_sel <= w_data[5:0];
          `BSF_A_STACK:
            if (w_strb[1])
            begin
              if (w_data[`BSF_F_STK_ERR])
                stack_err <= 1'b0;
              if (w_data[`BSF_F_BAD_OP])
                bad_op <= 1'b0;
            end
          default:
            ;
        endcase
      end
    end
  end

  // General purpose registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (i = 0; i < `BSF_GPR_COUNT; i = i + 1)
        gpr[i] <= `BSF_DATA_RST;
    end
    else if (ce && do_write)
    begin
      if (do_cmd && alu_known && alu_write)
        gpr[cmd_reg] <= alu_result;
      else if (stk_pop)
        gpr[cmd_reg] <= stk_top;
      else if (!do_cmd && aw_addr == `BSF_A_REG_DATA && w_strb[0])
        gpr[reg_sel] <= w_data[7:0];
    end
  end

  // I/O register space
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (j = 0; j < `BSF_IO_COUNT; j = j + 1)
        io_mem[j] <= `BSF_DATA_RST;
    end
    else if (ce && do_write)
    begin
      if (do_cmd && is_io_set)
        io_mem[cmd_io] <= io_word | (8'h01 << cmd_bit);
      else if (do_cmd && is_io_clr)
        io_mem[cmd_io] <= io_word & ~(8'h01 << cmd_bit);
      else if (!do_cmd && aw_addr == `BSF_A_IO_DATA && w_strb[0])
        io_mem[io_sel] <= w_data[7:0];
    end
  end

  // Read data selection
  always @*
  begin
    next_rdata = 32'h0000_0000;
    next_rresp = `BSF_RESP_OKAY;
    case (s_axi_araddr)
      `BSF_A_CMD:      next_rdata = cmd_word;
      `BSF_A_STATUS:   next_rdata[7:0] = cpu_status_register;
      `BSF_A_REG_SEL:  next_rdata[4:0] = reg_sel;
      `BSF_A_REG_DATA: next_rdata[7:0] = gpr[reg_sel];
      `BSF_A_IO_SEL:   next_rdata[5:0] = io_sel;
      `BSF_A_IO_DATA:  next_rdata[7:0] = io_mem[io_sel];
      `BSF_A_STACK:
      begin
        next_rdata[4:0]              = stk_depth;
        next_rdata[`BSF_F_STK_EMPTY] = stk_empty;
        next_rdata[`BSF_F_STK_FULL]  = stk_full;
        next_rdata[`BSF_F_STK_ERR]   = stack_err;
        next_rdata[`BSF_F_BAD_OP]    = bad_op;
      end
      default:         next_rresp = `BSF_RESP_SLVERR;
    endcase
  end

  // Read channel
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `BSF_RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= next_rresp;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// File: bsf_top_tb_top.sv
// Self-checking bench for bsf_top with a behavioural model of flags, registers and stack.
// Assumes the map and opcodes of bsf_map.vh; the prot inputs are tied, ce drops once while idle.
`timescale 1ns/100ps
`include "bsf_map.vh"
module bsf_top_tb_top;
  logic        aclk = 0, aresetn = 0, ce = 1;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, rd;
  logic [3:0]  s_axi_wstrb = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, global_irq_en;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [7:0]  cpu_status_register;
  int          error_cnt = 0, n_tests = 0, seed = 32'h6b74;
  int          fb[6] = '{`BSF_FLAG_C, `BSF_FLAG_N, `BSF_FLAG_Z, `BSF_FLAG_I, `BSF_FLAG_S, `BSF_FLAG_V};
  logic [7:0]  gpr[32], io[64], st, stk[$];
  logic        sterr, badop;

  bsf_top bsf_top_inst (.*);

  initial forever #20 aclk = ~aclk;

  task final_report;
    if (error_cnt == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task chk_data(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD data t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD resp t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] rs;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    for (int n = 0; n < 40; n++)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tb)
      begin
        s_axi_bready <= 0;
        chk_resp(rs, er);
        return;
      end
    end
    error_cnt++;
    final_report;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
    logic ta, tb;
    logic [1:0] rs;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    for (int n = 0; n < 40; n++)
    begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tb = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 0;
      if (tb)
      begin
        s_axi_rready <= 0;
        chk_resp(rs, er);
        return;
      end
    end
    error_cnt++;
    final_report;
  endtask

  task automatic check_all(input logic [4:0] r, input logic [5:0] p);
    axi_rd(8'h04, 0);
    chk_data(rd, st);
    chk_data(cpu_status_register, st);
    chk_data(global_irq_en, st[7]);
    axi_wr(8'h08, r, 4'hf, 0);
    axi_rd(8'h0c, 0);
    chk_data(rd, gpr[r]);
    axi_wr(8'h10, p, 4'hf, 0);
    axi_rd(8'h14, 0);
    chk_data(rd, io[p]);
    axi_rd(8'h18, 0);
    chk_data(rd, {badop, sterr, 1'b0, stk.size() == 16, stk.size() == 0, 5'(stk.size())});
  endtask

  // Model one command, issue it, then compare everything it may touch
  task automatic run_cmd(input logic [4:0] op, input logic [4:0] r, input logic [2:0] b, input logic [5:0] p);
    logic [7:0] d;
    logic c;
    logic [31:0] cw;
    d = gpr[r];
    c = st[0];
    case (op)
      5'h00: if (stk.size() < 16) stk.push_back(d); else sterr = 1;
      5'h01: if (stk.size() > 0) gpr[r] = stk.pop_back(); else sterr = 1;
      5'h02: io[p][b] = 1;
      5'h03: io[p][b] = 0;
      5'h04: {c, d} = {d, 1'b0};
      5'h05: {d, c} = {1'b0, d};
      5'h06: {c, d} = {d, st[0]};
      5'h07: {d, c} = {st[0], d};
      5'h08: {d, c} = {d[7], d};
      5'h09: gpr[r] = {d[3:0], d[7:4]};
      5'h0a: st[b] = 1;
      5'h0b: st[b] = 0;
      5'h0c: st[`BSF_FLAG_T] = d[b];
      5'h0d: gpr[r][b] = st[`BSF_FLAG_T];
      5'h1a: st[`BSF_FLAG_T] = 1;
      default: if (op > 5'h1a) badop = 1; else st[fb[(op - 5'h0e) >> 1]] = !op[0];
    endcase
    if (op >= 5'h04 && op <= 5'h08)
    begin
      gpr[r] = d;
      st[3:0] = {d[7] ^ c, d[7], d == 0, c};
    end
    cw = {2'b0, p, 5'b0, b, 3'b0, r, 3'b0, op};
    axi_wr(8'h00, cw, 4'hf, 0);
    axi_rd(8'h00, 0);
    chk_data(rd, cw);
    check_all(r, p);
  endtask

  initial
  begin
    logic [31:0] v, w;
    foreach (gpr[i]) gpr[i] = 0;
    foreach (io[i]) io[i] = 0;
    {st, sterr, badop} = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    check_all(0, 0);
    for (int i = 0; i < 96; i++)
    begin
      v = $random(seed);
      w = $random(seed);
      st = w[7:0];
      gpr[v[4:0]] = v[31:24];
      io[v[21:16]] = w[15:8];
      axi_wr(8'h04, w[7:0], 4'hf, 0);
      axi_wr(8'h08, v[4:0], 4'hf, 0);
      axi_wr(8'h0c, v[31:24], 4'hf, 0);
      axi_wr(8'h10, v[21:16], 4'hf, 0);
      axi_wr(8'h14, w[15:8], 4'hf, 0);
      run_cmd(i[4:0], v[4:0], v[10:8], v[21:16]);
    end
    // Overfill then overdrain the stack
    for (int i = 0; i < 36; i++) run_cmd(5'(i / 18), i[4:0], 0, 0);
    axi_wr(8'h18, 32'h300, 4'h1, 0);
    check_all(0, 0);
    axi_wr(8'h18, 32'h300, 4'hf, 0);
    {sterr, badop} = 0;
    run_cmd(5'h0f, 0, 0, 0);
    axi_wr(8'h00, 32'h0e, 4'h7, 0);
    check_all(0, 0);
    axi_wr(8'h1c, 32'h1, 4'hf, 2'b10);
    axi_rd(8'h40, 2'b10);
    chk_data(rd, 0);
    check_all(0, 0);
    // With ce low every ready must drop and no state may move
    ce <= 0;
    @(negedge aclk);
    chk_data({s_axi_awready, s_axi_wready, s_axi_arready}, 0);
    @(posedge aclk);
    ce <= 1;
    check_all(0, 0);
    final_report;
  end
endmodule
